/* File: cls_pkg.sv */
// shared constants for the current loop output select block
package cls_pkg;

  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int MEAS_W = 16;  // signed measurement value
  localparam int CUR_W  = 15;  // loop current, 1 uA per lsb
  localparam int SEL_W  = 4;

  // ------------------------------------------------------------------
  // output range codes
  // ------------------------------------------------------------------
  localparam logic [2:0] RANGE_OFF     = 3'h0;
  localparam logic [2:0] RANGE_0_FULL  = 3'h1;
  localparam logic [2:0] RANGE_4_FULL  = 3'h2;
  localparam logic [2:0] RANGE_FULL_0  = 3'h3;
  localparam logic [2:0] RANGE_FULL_4  = 3'h4;
  localparam logic [2:0] RANGE_DEFAULT = RANGE_4_FULL;

  // ------------------------------------------------------------------
  // output function codes
  // ------------------------------------------------------------------
  localparam logic [3:0] FN_OFF      = 4'h0;
  localparam logic [3:0] FN_LEVEL    = 4'h1;
  localparam logic [3:0] FN_SPACE    = 4'h2;
  localparam logic [3:0] FN_DISTANCE = 4'h3;
  localparam logic [3:0] FN_VOL_RATE = 4'h7;
  localparam logic [3:0] FN_CUR_IN   = 4'h8;
  localparam logic [3:0] FN_COMMS_IN = 4'h9;
  localparam logic [3:0] FN_SMALL_MAX = FN_DISTANCE;
  localparam logic [3:0] FN_DEFAULT  = FN_LEVEL;

  // ------------------------------------------------------------------
  // operation modes that allow reallocation on a single point unit
  // ------------------------------------------------------------------
  localparam logic [3:0] OP_DUAL_DIFF = 4'h4;
  localparam logic [3:0] OP_DUAL_AVG  = 4'h5;

  // ------------------------------------------------------------------
  // setting write selectors
  // ------------------------------------------------------------------
  localparam logic [3:0] SEL_RANGE   = 4'h0;
  localparam logic [3:0] SEL_FUNC    = 4'h1;
  localparam logic [3:0] SEL_ALLOC   = 4'h2;
  localparam logic [3:0] SEL_MIN     = 4'h3;
  localparam logic [3:0] SEL_MAX     = 4'h4;
  localparam logic [3:0] SEL_LO_TRIM = 4'h5;
  localparam logic [3:0] SEL_HI_TRIM = 4'h6;
  localparam logic [3:0] SEL_SP_LOW  = 4'h7;
  localparam logic [3:0] SEL_SP_HIGH = 4'h8;

  // allocation word: [1:0] first point, [3:2] range end (0 = single)
  localparam int ALLOC_START_LSB = 0;
  localparam int ALLOC_END_LSB   = 2;

  // ------------------------------------------------------------------
  // current figures in uA and reset values
  // ------------------------------------------------------------------
  localparam logic [CUR_W-1:0] CUR_ZERO    = 15'h0000;
  localparam logic [CUR_W-1:0] CUR_FOUR    = 15'h0FA0;  // 4.000
  localparam logic [CUR_W-1:0] CUR_FULL    = 15'h4E20;  // 20.000
  localparam logic [CUR_W-1:0] CUR_CEIL    = 15'h55F0;  // 22.000
  localparam logic [CUR_W-1:0] MIN_DEFAULT = 15'h0ED8;  // 3.800
  localparam logic [CUR_W-1:0] MAX_DEFAULT = 15'h4EE8;  // 20.200
  localparam logic [CUR_W-1:0] LO_TRIM_DEFAULT = CUR_FOUR;
  localparam logic [CUR_W-1:0] HI_TRIM_DEFAULT = CUR_FULL;
  localparam logic signed [MEAS_W-1:0] SP_LOW_DEFAULT  = 16'sh0000;
  localparam logic signed [MEAS_W-1:0] SP_HIGH_DEFAULT = 16'sh0064;
  localparam logic [1:0] ALLOC_START_DEFAULT = 2'h1;

endpackage

/* File: cls_avg.sv */
// average of the in-service points inside one allocated range
module cls_avg #(
  parameter int NPTS = 3
) (
  input  wire logic signed [cls_pkg::MEAS_W-1:0] pt_value [NPTS],
  input  wire logic [NPTS-1:0]                   pt_in_service,
  input  wire logic [1:0]                        first_pt,
  input  wire logic [1:0]                        last_pt,
  output logic signed [cls_pkg::MEAS_W-1:0]      avg_value,
  output logic                                   avg_valid
);

  logic signed [cls_pkg::MEAS_W+3:0] sum;
  logic [3:0]                        cnt;
  logic [1:0]                        last_eff;

  always_comb begin
    // an end of zero means one point only
    last_eff = (last_pt == 2'h0) ? first_pt : last_pt;  // R10
    sum = '0;
    cnt = 4'h0;
    for (int i = 0; i < NPTS; i++) begin
      // out of service points drop out of the sum and the count
      if ((i + 1) >= int'(first_pt) && (i + 1) <= int'(last_eff) && pt_in_service[i]) begin  // R9
        sum = sum + (cls_pkg::MEAS_W+4)'(pt_value[i]);
        cnt = cnt + 4'h1;
      end
    end
    avg_valid = (cnt != 4'h0);
    avg_value = avg_valid ? cls_pkg::MEAS_W'(sum / $signed({1'b0, cnt})) : '0;
  end

endmodule

/* File: cls_scale.sv */
// linear mapping of a function value onto the loop current, clamp and trim
module cls_scale (
  input  wire logic signed [cls_pkg::MEAS_W-1:0] func_value,
  input  wire logic signed [cls_pkg::MEAS_W-1:0] sp_low,
  input  wire logic signed [cls_pkg::MEAS_W-1:0] sp_high,
  input  wire logic [2:0]                        range_sel,
  input  wire logic [cls_pkg::CUR_W-1:0]         min_limit,
  input  wire logic [cls_pkg::CUR_W-1:0]         max_limit,
  input  wire logic [cls_pkg::CUR_W-1:0]         lo_trim,
  input  wire logic [cls_pkg::CUR_W-1:0]         hi_trim,
  output logic [cls_pkg::CUR_W-1:0]              ideal_cur,
  output logic [cls_pkg::CUR_W-1:0]              phys_cur
);

  logic signed [39:0] lo_end;
  logic signed [39:0] hi_end;
  logic signed [39:0] span;
  logic signed [39:0] raw;
  logic signed [39:0] clamped;
  logic signed [39:0] trimmed;

  function automatic logic signed [39:0] clip(input logic signed [39:0] v,
                                              input logic signed [39:0] lo,
                                              input logic signed [39:0] hi);
    clip = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_comb begin
    // direct ranges rise with the value, inverse ones fall
    case (range_sel)
      cls_pkg::RANGE_0_FULL: begin lo_end = 40'(cls_pkg::CUR_ZERO); hi_end = 40'(cls_pkg::CUR_FULL); end  // R2
      cls_pkg::RANGE_4_FULL: begin lo_end = 40'(cls_pkg::CUR_FOUR); hi_end = 40'(cls_pkg::CUR_FULL); end  // R2
      cls_pkg::RANGE_FULL_0: begin lo_end = 40'(cls_pkg::CUR_FULL); hi_end = 40'(cls_pkg::CUR_ZERO); end  // R2
      cls_pkg::RANGE_FULL_4: begin lo_end = 40'(cls_pkg::CUR_FULL); hi_end = 40'(cls_pkg::CUR_FOUR); end  // R2
      default:               begin lo_end = 40'(cls_pkg::CUR_ZERO); hi_end = 40'(cls_pkg::CUR_ZERO); end
    endcase
    span = 40'(sp_high) - 40'(sp_low);
    // a zero span would divide by zero, so it pins to the low end
    raw = (span == 40'sd0) ? lo_end :
          lo_end + ((40'(func_value) - 40'(sp_low)) * (hi_end - lo_end)) / span;  // R18
    clamped = clip(raw, 40'(min_limit), 40'(max_limit));  // R17
    clamped = clip(clamped, 40'(cls_pkg::CUR_ZERO), 40'(cls_pkg::CUR_CEIL));
    if (range_sel == cls_pkg::RANGE_OFF) begin
      clamped = 40'sd0;  // R1
    end
    // trim moves only the physical current, the viewed value stays untrimmed
    // every operand signed, so a view below 4 mA does not wrap the product
    trimmed = $signed(40'(lo_trim)) + ((clamped - $signed(40'(cls_pkg::CUR_FOUR)))
              * ($signed(40'(hi_trim)) - $signed(40'(lo_trim))))
              / $signed(40'(cls_pkg::CUR_FULL) - 40'(cls_pkg::CUR_FOUR));  // R12
    trimmed = (range_sel == cls_pkg::RANGE_OFF) ? 40'sd0 :
              clip(trimmed, 40'(cls_pkg::CUR_ZERO), 40'(cls_pkg::CUR_CEIL));
    ideal_cur = clamped[cls_pkg::CUR_W-1:0];
    phys_cur  = trimmed[cls_pkg::CUR_W-1:0];
  end

endmodule

/* File: cls_output_select.sv */
// current loop output channels: range, function, allocation, limits, per point view
// ------------------------------------------------------------------
// Contract
// R1 - range codes: off, 0-20, 4-20, 20-0, 20-4
// R2 - codes 1,2 direct; codes 3,4 inverse
// R3 - range write leaves minimum limit untouched
// R4 - large variant function codes zero to nine
// R5 - small variant accepts functions zero to three
// R6 - allocation: point 1, 2, 1:2, 3 large
// R7 - point meaning depends on function source kind
// R8 - single point: reallocation only in dual modes
// R9 - range averages in-service points, others ignored
// R10 - range end zero means single transducer
// R11 - read-only per point current, 0 to 22
// R12 - per point value excludes trim corrections
// R13 - one output per point: its value
// R14 - multi point output: averaged derived value
// R15 - several outputs per point: first wins
// R16 - per point value valid only when sourced
// R17 - clamp to min 3.8 and max 20.2
// R18 - recompute once per measurement update
// ------------------------------------------------------------------
module cls_output_select #(
  parameter int NCH          = 2,
  parameter int NPTS         = 3,
  parameter bit LARGE        = 1'b1,
  parameter bit SINGLE_POINT = 1'b0
) (
  input  wire logic                              clock,
  input  wire logic                              rst_b,
  input  wire logic                              cfg_wr_en,
  input  wire logic [$clog2(NCH)-1:0]            cfg_wr_chan,
  input  wire logic [cls_pkg::SEL_W-1:0]         cfg_wr_sel,
  input  wire logic [cls_pkg::MEAS_W-1:0]        cfg_wr_data,
  input  wire logic [3:0]                        operation_mode,
  input  wire logic                              meas_update,
  input  wire logic signed [cls_pkg::MEAS_W-1:0] pt_value [NPTS],
  input  wire logic [NPTS-1:0]                   pt_in_service,
  input  wire logic signed [cls_pkg::MEAS_W-1:0] cur_input_value,
  input  wire logic signed [cls_pkg::MEAS_W-1:0] comms_input_value,
  output logic                                   cfg_rejected,
  output logic [2:0]                             output_range_select [NCH],
  output logic [3:0]                             output_function_select [NCH],
  output logic [3:0]                             output_source_allocation [NCH],
  output logic [cls_pkg::CUR_W-1:0]              output_value_view [NCH],
  output logic [cls_pkg::CUR_W-1:0]              ma_out_value [NCH],
  output logic                                   ma_out_strobe,
  output logic [cls_pkg::CUR_W-1:0]              per_point_output_value [NPTS],
  output logic [NPTS-1:0]                        per_point_valid
);

  // ------------------------------------------------------------------
  // settings
  // ------------------------------------------------------------------
  logic [2:0]                        range_ff    [NCH];
  logic [3:0]                        func_ff     [NCH];
  logic [1:0]                        a_start_ff  [NCH];
  logic [1:0]                        a_end_ff    [NCH];
  logic [cls_pkg::CUR_W-1:0]         min_ff      [NCH];
  logic [cls_pkg::CUR_W-1:0]         max_ff      [NCH];
  logic [cls_pkg::CUR_W-1:0]         lo_trim_ff  [NCH];
  logic [cls_pkg::CUR_W-1:0]         hi_trim_ff  [NCH];
  logic signed [cls_pkg::MEAS_W-1:0] sp_low_ff   [NCH];
  logic signed [cls_pkg::MEAS_W-1:0] sp_high_ff  [NCH];
  logic                              rej_ff;
  logic                              nxt_rej;

  function automatic logic fn_transducer(input logic [3:0] fn);
    fn_transducer = (fn >= cls_pkg::FN_LEVEL) && (fn <= cls_pkg::FN_VOL_RATE);
  endfunction

  function automatic logic fn_supported(input logic [3:0] fn);
    fn_supported = LARGE ? (fn <= cls_pkg::FN_COMMS_IN) : (fn <= cls_pkg::FN_SMALL_MAX);  // R4 R5
  endfunction

  function automatic logic alloc_ok(input logic [1:0] st, input logic [1:0] en);
    // legal: 1, 2, 1:2, and 3 on the large variant only
    alloc_ok = (en == 2'h0 && (st == 2'h1 || st == 2'h2 || (LARGE && st == 2'h3)))
            || (st == 2'h1 && en == 2'h2);  // R6
  endfunction

  logic [1:0] wr_start;
  logic [1:0] wr_end;
  logic       alloc_locked;

  assign wr_start = cfg_wr_data[cls_pkg::ALLOC_START_LSB +: 2];
  assign wr_end   = cfg_wr_data[cls_pkg::ALLOC_END_LSB +: 2];
  // a single point unit keeps its transducer source unless in a dual mode
  assign alloc_locked = SINGLE_POINT && fn_transducer(func_ff[cfg_wr_chan])
                     && operation_mode != cls_pkg::OP_DUAL_DIFF
                     && operation_mode != cls_pkg::OP_DUAL_AVG;  // R8

  always_comb begin
    nxt_rej = 1'b0;
    if (cfg_wr_en) begin
      case (cfg_wr_sel)
        cls_pkg::SEL_RANGE: nxt_rej = cfg_wr_data > 16'(cls_pkg::RANGE_FULL_4);  // R1
        cls_pkg::SEL_FUNC:  nxt_rej = !fn_supported(cfg_wr_data[3:0]) || (|cfg_wr_data[15:4]);
        cls_pkg::SEL_ALLOC: nxt_rej = alloc_locked || !alloc_ok(wr_start, wr_end);  // R8
        cls_pkg::SEL_MIN, cls_pkg::SEL_MAX, cls_pkg::SEL_LO_TRIM, cls_pkg::SEL_HI_TRIM:
          nxt_rej = cfg_wr_data > 16'(cls_pkg::CUR_CEIL);
        cls_pkg::SEL_SP_LOW, cls_pkg::SEL_SP_HIGH: nxt_rej = 1'b0;
        default: nxt_rej = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rej_ff <= 1'b0;
    end else begin
      rej_ff <= nxt_rej;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH; c++) begin
        range_ff[c]   <= cls_pkg::RANGE_DEFAULT;
        func_ff[c]    <= cls_pkg::FN_DEFAULT;
        a_start_ff[c] <= cls_pkg::ALLOC_START_DEFAULT;
        a_end_ff[c]   <= 2'h0;
        min_ff[c]     <= cls_pkg::MIN_DEFAULT;
        max_ff[c]     <= cls_pkg::MAX_DEFAULT;
        lo_trim_ff[c] <= cls_pkg::LO_TRIM_DEFAULT;
        hi_trim_ff[c] <= cls_pkg::HI_TRIM_DEFAULT;
        sp_low_ff[c]  <= cls_pkg::SP_LOW_DEFAULT;
        sp_high_ff[c] <= cls_pkg::SP_HIGH_DEFAULT;
      end
    end else if (cfg_wr_en && !nxt_rej) begin
      case (cfg_wr_sel)
        // the minimum limit is deliberately not re-derived here
        cls_pkg::SEL_RANGE:   range_ff[cfg_wr_chan]   <= cfg_wr_data[2:0];  // R3
        cls_pkg::SEL_FUNC:    func_ff[cfg_wr_chan]    <= cfg_wr_data[3:0];  // R4
        cls_pkg::SEL_ALLOC: begin
          a_start_ff[cfg_wr_chan] <= wr_start;  // R6
          a_end_ff[cfg_wr_chan]   <= wr_end;
        end
        cls_pkg::SEL_MIN:     min_ff[cfg_wr_chan]     <= cfg_wr_data[cls_pkg::CUR_W-1:0];
        cls_pkg::SEL_MAX:     max_ff[cfg_wr_chan]     <= cfg_wr_data[cls_pkg::CUR_W-1:0];
        cls_pkg::SEL_LO_TRIM: lo_trim_ff[cfg_wr_chan] <= cfg_wr_data[cls_pkg::CUR_W-1:0];
        cls_pkg::SEL_HI_TRIM: hi_trim_ff[cfg_wr_chan] <= cfg_wr_data[cls_pkg::CUR_W-1:0];
        cls_pkg::SEL_SP_LOW:  sp_low_ff[cfg_wr_chan]  <= cfg_wr_data;
        cls_pkg::SEL_SP_HIGH: sp_high_ff[cfg_wr_chan] <= cfg_wr_data;
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // per channel value path
  // ------------------------------------------------------------------
  logic signed [cls_pkg::MEAS_W-1:0] avg_val   [NCH];
  logic                              avg_ok    [NCH];
  logic signed [cls_pkg::MEAS_W-1:0] fval      [NCH];
  logic                              fval_ok   [NCH];
  logic [cls_pkg::CUR_W-1:0]         ideal     [NCH];
  logic [cls_pkg::CUR_W-1:0]         phys      [NCH];
  logic [2:0]                        eff_range [NCH];
  logic [cls_pkg::CUR_W-1:0]         ideal_ff  [NCH];
  logic [cls_pkg::CUR_W-1:0]         phys_ff   [NCH];

  for (genvar c = 0; c < NCH; c++) begin : g_chan
    cls_avg #(
      .NPTS (NPTS)
    ) u_avg (
      .pt_value      (pt_value),
      .pt_in_service (pt_in_service),
      .first_pt      (a_start_ff[c]),
      .last_pt       (a_end_ff[c]),
      .avg_value     (avg_val[c]),
      .avg_valid     (avg_ok[c])
    );

    always_comb begin
      // transducer functions use points; inputs ignore the point number
      if (fn_transducer(func_ff[c])) begin  // R7
        fval[c]    = avg_val[c];  // R14
        fval_ok[c] = avg_ok[c];
      end else if (func_ff[c] == cls_pkg::FN_CUR_IN) begin
        fval[c]    = cur_input_value;  // R7
        fval_ok[c] = 1'b1;
      end else begin
        fval[c]    = comms_input_value;
        fval_ok[c] = (func_ff[c] == cls_pkg::FN_COMMS_IN);
      end
      // function off forces the output off as well
      eff_range[c] = (func_ff[c] == cls_pkg::FN_OFF) ? cls_pkg::RANGE_OFF : range_ff[c];  // R1
    end

    cls_scale u_scale (
      .func_value (fval[c]),
      .sp_low     (sp_low_ff[c]),
      .sp_high    (sp_high_ff[c]),
      .range_sel  (eff_range[c]),
      .min_limit  (min_ff[c]),
      .max_limit  (max_ff[c]),
      .lo_trim    (lo_trim_ff[c]),
      .hi_trim    (hi_trim_ff[c]),
      .ideal_cur  (ideal[c]),
      .phys_cur   (phys[c])
    );
  end

  // with no in-service source the last value is held
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < NCH; c++) begin
        ideal_ff[c] <= cls_pkg::CUR_ZERO;
        phys_ff[c]  <= cls_pkg::CUR_ZERO;
      end
    end else if (meas_update) begin  // R18
      for (int c = 0; c < NCH; c++) begin
        if (fval_ok[c] || eff_range[c] == cls_pkg::RANGE_OFF) begin
          ideal_ff[c] <= ideal[c];
          phys_ff[c]  <= phys[c];
        end
      end
    end
  end

  logic strobe_ff;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      strobe_ff <= 1'b0;
    end else begin
      strobe_ff <= meas_update;
    end
  end

  // ------------------------------------------------------------------
  // per point view
  // ------------------------------------------------------------------
  logic [cls_pkg::CUR_W-1:0] view_ff     [NPTS];
  logic [cls_pkg::CUR_W-1:0] nxt_view    [NPTS];
  logic [NPTS-1:0]           view_ok_ff;
  logic [NPTS-1:0]           nxt_view_ok;
  logic [1:0]                last_eff;

  always_comb begin
    last_eff = 2'h0;
    for (int p = 0; p < NPTS; p++) begin
      nxt_view[p]    = cls_pkg::CUR_ZERO;
      nxt_view_ok[p] = 1'b0;
      // walk channels downward so the lowest sourcing channel is left standing
      for (int c = NCH - 1; c >= 0; c--) begin
        last_eff = (a_end_ff[c] == 2'h0) ? a_start_ff[c] : a_end_ff[c];
        if (fn_transducer(func_ff[c]) && (p + 1) >= int'(a_start_ff[c])
            && (p + 1) <= int'(last_eff)) begin  // R16
          nxt_view[p]    = ideal[c];  // R13 R14 R15 R12
          nxt_view_ok[p] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      view_ok_ff <= '0;
      for (int p = 0; p < NPTS; p++) begin
        view_ff[p] <= cls_pkg::CUR_ZERO;
      end
    end else if (meas_update) begin
      view_ok_ff <= nxt_view_ok;  // R16
      for (int p = 0; p < NPTS; p++) begin
        view_ff[p] <= nxt_view[p];  // R11
      end
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      output_range_select[c]      = range_ff[c];
      output_function_select[c]   = func_ff[c];
      output_source_allocation[c] = {a_end_ff[c], a_start_ff[c]};
      output_value_view[c]        = ideal_ff[c];
      ma_out_value[c]             = phys_ff[c];
    end
    for (int p = 0; p < NPTS; p++) begin
      per_point_output_value[p] = view_ff[p];
    end
  end

  assign per_point_valid = view_ok_ff;
  assign ma_out_strobe   = strobe_ff;
  assign cfg_rejected    = rej_ff;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  off_output_zero_a: assert property ( // R1
    meas_update && eff_range[0] == cls_pkg::RANGE_OFF |=> ideal_ff[0] == cls_pkg::CUR_ZERO
      && phys_ff[0] == cls_pkg::CUR_ZERO)
    else $error("off range did not give zero current");

  min_kept_a: assert property ( // R3
    cfg_wr_en && cfg_wr_sel == cls_pkg::SEL_RANGE
      |=> $stable(min_ff[0]) && $stable(min_ff[NCH-1]))
    else $error("range write altered the minimum limit");

  func_reject_a: assert property ( // R5
    cfg_wr_en && cfg_wr_sel == cls_pkg::SEL_FUNC && !LARGE && cfg_wr_data > 16'h0003
      |=> cfg_rejected && $stable(func_ff[0]) && $stable(func_ff[NCH-1]))
    else $error("unsupported function code was accepted");

  alloc_lock_a: assert property ( // R8
    cfg_wr_en && cfg_wr_sel == cls_pkg::SEL_ALLOC && alloc_locked
      |=> cfg_rejected && $stable(a_start_ff[0]) && $stable(a_start_ff[NCH-1]))
    else $error("locked allocation was changed");

  clamp_limit_a: assert property ( // R17
    strobe_ff && range_ff[0] != cls_pkg::RANGE_OFF && func_ff[0] != cls_pkg::FN_OFF
      && $past(fval_ok[0]) && $stable(range_ff[0]) && $stable(func_ff[0])
      && min_ff[0] <= max_ff[0] && $stable(min_ff[0]) && $stable(max_ff[0])
      |-> ideal_ff[0] >= min_ff[0] && ideal_ff[0] <= max_ff[0])
    else $error("output outside its limits");

  update_only_a: assert property ( // R18
    !meas_update |=> $stable(ideal_ff[0]) && $stable(view_ff[0]))
    else $error("output moved without a measurement update");

  view_first_a: assert property ( // R15
    meas_update && fn_transducer(func_ff[0]) && a_start_ff[0] == 2'h1
      |=> per_point_valid[0] && per_point_output_value[0] == $past(ideal[0]))
    else $error("per point view not from first sourcing output");

  single_point_a: assert property ( // R10
    a_end_ff[0] == 2'h0 && a_start_ff[0] == 2'h1 && pt_in_service[0]
      |-> avg_ok[0] && avg_val[0] == pt_value[0])
    else $error("single allocation did not pass the point through");

  update_cover_c: cover property (meas_update ##1 ma_out_strobe);
  reject_cover_c: cover property (cfg_wr_en ##1 cfg_rejected);
  average_cover_c: cover property (meas_update && a_end_ff[0] == 2'h2 && &pt_in_service[1:0]);
  inverse_cover_c: cover property (meas_update && range_ff[0] == cls_pkg::RANGE_FULL_4);

endmodule

/* File: cls_loop_rx.sv */
// receiving instrument on the current loop: latches the loop current at each update
module cls_loop_rx (
  input  wire logic                      clock,
  input  wire logic                      rst_b,
  input  wire logic                      take,
  input  wire logic [cls_pkg::CUR_W-1:0] loop_cur,
  output logic [cls_pkg::CUR_W-1:0]      reading
);
  timeunit 1ns;
  timeprecision 100ps;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) reading <= '0;
    else if (take) reading <= loop_cur;
  end
endmodule

/* File: current_loop_output_select_tb.sv */
// self-checking bench for the current loop output select block
module current_loop_output_select_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic              clock = 1'b0, rst_b = 1'b0, wr_en = 1'b0, upd_en = 1'b0;
  logic [3:0]        wr_sel = '0;
  logic [15:0]       wr_data = '0;
  logic signed [15:0] pt [3] = '{default: '0};
  logic signed [15:0] cur_in = '0, comms_in = '0;
  logic [2:0]        insv = 3'h7;
  logic [31:0]       seed = 32'h6CA27CC4;
  logic              rej, rej_sp;
  logic [3:0]        op_mode = 4'h0;
  logic [3:0]        fsel [2];
  logic [2:0]        ppok;
  logic [14:0]       view [2], mao [2], ppv [3], rx;
  logic [29:0]       q [$];
  logic [29:0]       note;
  int                fails = 0, checks_done = 0, cyc = 0, v;

  always #12.5 clock = ~clock;

  cls_output_select dut (.clock(clock), .rst_b(rst_b), .cfg_wr_en(wr_en), .cfg_wr_chan(1'b0),
    .cfg_wr_sel(wr_sel), .cfg_wr_data(wr_data), .operation_mode(op_mode), .meas_update(upd_en),
    .pt_value(pt), .pt_in_service(insv), .cur_input_value(cur_in),
    .comms_input_value(comms_in), .cfg_rejected(rej), .output_range_select(),
    .output_function_select(fsel), .output_source_allocation(), .output_value_view(view),
    .ma_out_value(mao), .ma_out_strobe(), .per_point_output_value(ppv), .per_point_valid(ppok));
  // small single point variant sees the same writes, only its refusals are checked
  cls_output_select #(.LARGE(1'b0), .SINGLE_POINT(1'b1)) dut_sp (.clock(clock), .rst_b(rst_b),
    .cfg_wr_en(wr_en), .cfg_wr_chan(1'b0), .cfg_wr_sel(wr_sel), .cfg_wr_data(wr_data),
    .operation_mode(op_mode), .meas_update(upd_en), .pt_value(pt), .pt_in_service(insv),
    .cur_input_value(cur_in), .comms_input_value(comms_in), .cfg_rejected(rej_sp),
    .output_range_select(), .output_function_select(), .output_source_allocation(),
    .output_value_view(), .ma_out_value(), .ma_out_strobe(), .per_point_output_value(),
    .per_point_valid());
  cls_loop_rx rx_model (.clock(clock), .rst_b(rst_b), .take(dut.ma_out_strobe),
    .loop_cur(mao[0]), .reading(rx));

  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [14:0] exp_view(int x, int r);
    int lo, hi, o;
    lo = (r == 1) ? 0 : (r == 2) ? 4000 : 20000;
    hi = (r == 3) ? 0 : (r == 4) ? 4000 : 20000;
    o = lo + x * (hi - lo) / 100;
    o = (o < 3800) ? 3800 : (o > 20200) ? 20200 : o;
    return (r == 0) ? 15'h0000 : 15'(o);
  endfunction

  task automatic chk(string n, logic [14:0] seen, logic [14:0] e);
    checks_done++;
    if (seen !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // e[0] is the refusal expected of the large unit, e[1] that of the small one
  task automatic wr(logic [3:0] s, logic [15:0] d, logic [1:0] e);
    wr_sel = s;
    wr_data = d;
    wr_en = 1'b1;
    @(posedge clock) #2;
    wr_en = 1'b0;
    chk("rejected", 15'(rej), 15'(e[0]));
    chk("small rejected", 15'(rej_sp), 15'(e[1]));
    @(posedge clock) #2;
  endtask

  // every update is noted in the queue; the watcher below pops it
  task automatic upd(int a, int b, logic [14:0] e, logic [14:0] pe);
    seed = lfsr(seed);
    pt = '{16'(a), 16'(b), 16'(seed[6:0])};
    comms_in = 16'(seed[15:8]);
    upd_en = 1'b1;
    q.push_back({e, pe});
    @(posedge clock) #2;
    upd_en = 1'b0;
    @(posedge clock) #2;
  endtask

  always @(negedge clock) begin
    if (dut.ma_out_strobe === 1'b1 && q.size() > 0) begin
      note = q.pop_front();
      chk("view", view[0], note[29:15]);
      chk("per point", ppv[0], note[14:0]);
      chk("point 1 valid", 15'(ppok[0]), 15'h0001);
      chk("point 3 valid", 15'(ppok[2]), 15'h0000);
    end
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    repeat (4) @(posedge clock);
    #2 rst_b = 1'b1;
    chk("range rst", 15'(dut.output_range_select[0]), 15'h0002);
    chk("alloc rst", 15'(dut.output_source_allocation[0]), 15'h0001);
    for (int r = 0; r < 6; r++) begin
      wr(cls_pkg::SEL_RANGE, 16'(r), {2{r > 4}});
      seed = lfsr(seed);
      v = int'(seed % 121);
      if (r < 5) upd(v, 7, exp_view(v, r), exp_view(v, r));
      if (r < 5) upd(0, 7, exp_view(0, r), exp_view(0, r));
    end
    wr(cls_pkg::SEL_RANGE, 16'h0002, 2'b00);
    wr(cls_pkg::SEL_FUNC, 16'h000C, 2'b11);
    wr(cls_pkg::SEL_FUNC, 16'h0008, 2'b10);
    chk("function", 15'(fsel[0]), 15'h0008);
    cur_in = 16'sh004B;
    upd(99, 7, exp_view(75, 2), exp_view(99, 2));
    wr(cls_pkg::SEL_FUNC, 16'h0001, 2'b00);
    wr(cls_pkg::SEL_ALLOC, 16'h0009, 2'b10);
    wr(cls_pkg::SEL_ALLOC, 16'h0000, 2'b11);
    op_mode = 4'h4;
    wr(cls_pkg::SEL_ALLOC, 16'h0009, 2'b00);
    upd(20, 61, exp_view(40, 2), exp_view(40, 2));
    insv = 3'h5;
    upd(20, 61, exp_view(20, 2), exp_view(20, 2));
    wr(cls_pkg::SEL_MIN, 16'd22001, 2'b11);
    wr(cls_pkg::SEL_LO_TRIM, 16'd5000, 2'b00);
    upd(50, 61, exp_view(50, 2), exp_view(50, 2));
    chk("loop current", rx, 15'd12500);
    close_out();
  end
endmodule
